// ==== src/sac_ctrl.sv ====
// Purpose: sequencing, result storage and dma addressing for a sar converter
// Assumes: apb slave, analog core answers via conv_done with conv_data
// Notes: one base channel number from the host side, plus the hold index per sample/hold
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl #(
    parameter bit HAS_DMA = 1'b1,
    parameter int NUM_BUF = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic cpu_idle,
    input wire logic external_interrupt_zero,
    input wire logic general_timer_b,
    input wire logic general_timer_c,
    input wire logic [3:0] scan_channel,
    input wire logic [3:0] manual_channel,
    input wire logic conv_done,
    input wire logic [11:0] conv_data,
    input wire logic [15:0] other_pin_config,
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_digital,
    output logic sample_hold_track,
    output logic [sac_pkg::NUM_SH-1:0] sample_enable,
    output logic conv_start,
    output logic [3:0] conv_channel,
    output logic scan_restart,
    output logic converter_irq_flag,
    output logic dma_request,
    output logic [10:0] dma_address
);
    import sac_pkg::*;
    logic [15:0] converter_control_one;
    logic [15:0] ctrl2;
    logic [15:0] timing;
    logic [15:0] pin_analog_config;
    logic [15:0] result_mem [NUM_BUF];
    logic [3:0] buf_ptr;
    logic [3:0] conv_cnt;
    logic [3:0] sh_idx;
    logic [4:0] acquire_active_cnt;
    logic [6:0] dma_slot;
    logic trig_ext_q;
    sac_state_t state;
    sac_state_t next_state;
    sac_res_if res ();

    sac_format u_format (
        .res(res)
    );

    wire logic conv_on = converter_control_one[BIT_ON];
    wire logic halted = cpu_idle && converter_control_one[BIT_HALT_IDLE];
    wire logic run = conv_on && !halted;
    wire logic res12 = converter_control_one[BIT_RES12];
    wire logic simultaneous_acquire = converter_control_one[BIT_SIMULTANEOUS_ACQUIRE] && !res12;
    wire logic auto_acquire_start = converter_control_one[BIT_AUTO_ACQUIRE_START];
    wire logic acquire_active = converter_control_one[BIT_ACQUIRE_ACTIVE];
    wire logic [2:0] trig = converter_control_one[TRIG_HI:TRIG_LO];
    wire logic [3:0] conversions_per_interrupt = ctrl2[CONVERSIONS_PER_INTERRUPT_HI:CONVERSIONS_PER_INTERRUPT_LO];
    wire logic scan_en = ctrl2[BIT_SCAN];
    wire logic [2:0] dmabl = timing[DMABL_HI:DMABL_LO];
    wire logic [4:0] samc = timing[SAMC_HI:SAMC_LO];

    wire logic wr = psel && penable && pwrite;
    wire logic rd_ok_buf = paddr >= ADDR_BUFBASE && paddr < ADDR_BUFBASE + 12'(NUM_BUF * 4);
    wire logic [3:0] buf_sel = paddr[5:2];
    wire logic hit_ctrl1 = paddr == ADDR_CTRL1;
    wire logic hit_ctrl2 = paddr == ADDR_CTRL2;
    wire logic hit_timing = paddr == ADDR_TIMING;
    wire logic hit_status = paddr == ADDR_STATUS;
    wire logic hit_result = paddr == ADDR_RESULT;
    wire logic hit_pin = paddr == ADDR_PINCFG;
    wire logic mapped = hit_ctrl1 || hit_ctrl2 || hit_timing || hit_status || hit_result
                        || hit_pin || (!HAS_DMA && rd_ok_buf);
    wire logic wr_ctrl1 = wr && hit_ctrl1;

    // trigger decode
    wire logic ext_edge = external_interrupt_zero && !trig_ext_q;
    wire logic trig_hit = trig == SAC_TRIG_AUTO ? acquire_active_cnt >= samc :
                          trig == SAC_TRIG_TMR_C ? general_timer_c :
                          trig == SAC_TRIG_TMR_B ? general_timer_b :
                          trig == SAC_TRIG_EXT ? ext_edge : 1'b0;
    wire logic sw_end = trig == SAC_TRIG_MANUAL && wr_ctrl1 && !pwdata[BIT_ACQUIRE_ACTIVE];
    wire logic end_sample = state == SAC_SAMPLE && (trig_hit || sw_end);
    wire logic sw_start = wr_ctrl1 && pwdata[BIT_ACQUIRE_ACTIVE] && !auto_acquire_start;
    wire logic last_sh = simultaneous_acquire ? sh_idx == 4'(NUM_SH - 1) : 1'b1;
    wire logic done_evt = state == SAC_CONVERT && conv_done;
    wire logic seq_done = done_evt && last_sh;
    wire logic count_hit = seq_done && conv_cnt == conversions_per_interrupt;
    wire logic [3:0] raw_ch = scan_en ? scan_channel : manual_channel;
    wire logic [3:0] ch_eff = raw_ch > CH_LAST ? CH_LAST : raw_ch;
    // base plus hold index may pass the last input, so clamp it too
    wire logic [4:0] ch_sum = {1'b0, ch_eff} + {1'b0, sh_idx};
    wire logic [3:0] ch_sim = ch_sum > {1'b0, CH_LAST} ? CH_LAST : ch_sum[3:0];
    wire logic [3:0] ch_now = simultaneous_acquire ? ch_sim : ch_eff;

    always_comb begin
        next_state = state;
        unique case (state)
            SAC_IDLE: begin
                if (run && (auto_acquire_start || sw_start))
                    next_state = SAC_SAMPLE;
            end
            SAC_SAMPLE: begin
                if (!run)
                    next_state = SAC_IDLE;
                else if (end_sample)
                    next_state = SAC_CONVERT;
            end
            SAC_CONVERT: begin
                if (!run)
                    next_state = SAC_IDLE;
                else if (seq_done)
                    next_state = auto_acquire_start ? SAC_SAMPLE : SAC_IDLE;
            end
            default: next_state = SAC_IDLE;
        endcase
    end

    assign res.raw = conv_data;
    assign res.res12 = res12;
    assign res.layout = converter_control_one[RESULT_LAYOUT_HI:RESULT_LAYOUT_LO];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state <= SAC_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acquire_active_cnt <= 5'h00;
            trig_ext_q <= 1'b0;
            sh_idx <= 4'h0;
        end else begin
            trig_ext_q <= external_interrupt_zero;
            acquire_active_cnt <= state == SAC_SAMPLE ? acquire_active_cnt + 5'h01 : 5'h00;
            if (state != SAC_CONVERT || seq_done)
                sh_idx <= 4'h0;
            else if (done_evt)
                sh_idx <= sh_idx + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_control_one <= RESET16;
        end else begin
            if (wr_ctrl1)
                converter_control_one <= (pwdata[15:0] & CTRL1_WMASK)
                    | (converter_control_one & ~CTRL1_WMASK);
            if (wr_ctrl1 && !pwdata[BIT_DONE])
                converter_control_one[BIT_DONE] <= 1'b0;
            if (state == SAC_CONVERT && next_state == SAC_SAMPLE)
                converter_control_one[BIT_ACQUIRE_ACTIVE] <= 1'b1;
            else if (state == SAC_IDLE && next_state == SAC_SAMPLE)
                converter_control_one[BIT_ACQUIRE_ACTIVE] <= 1'b1;
            else if (end_sample || !run)
                converter_control_one[BIT_ACQUIRE_ACTIVE] <= 1'b0;
            if (end_sample)
                converter_control_one[BIT_DONE] <= 1'b0;
            else if (seq_done)
                converter_control_one[BIT_DONE] <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl2 <= RESET16;
            timing <= RESET16;
            pin_analog_config <= RESET16;
        end else begin
            if (wr && hit_ctrl2)
                ctrl2 <= pwdata[15:0] & CTRL2_WMASK;
            if (wr && hit_timing)
                timing <= pwdata[15:0] & TIMING_WMASK;
            if (wr && hit_pin)
                pin_analog_config <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cnt <= 4'h0;
            buf_ptr <= 4'h0;
            dma_slot <= 7'h00;
            converter_irq_flag <= 1'b0;
            dma_request <= 1'b0;
            dma_address <= 11'h000;
        end else begin
            converter_irq_flag <= count_hit;
            dma_request <= HAS_DMA && count_hit;
            if (seq_done)
                conv_cnt <= count_hit ? 4'h0 : conv_cnt + 4'h1;
            if (done_evt)
                buf_ptr <= (count_hit || buf_ptr == 4'(NUM_BUF - 1)) ? 4'h0 : buf_ptr + 4'h1;
            if (count_hit) begin
                dma_slot <= dma_slot + 7'h01;
                if (converter_control_one[BIT_DMABM])
                    dma_address <= {7'h00, buf_ptr};
                else
                    dma_address <= 11'(({7'h00, ch_now} << dmabl) + 11'(dma_slot & 7'((8'h01 << dmabl) - 8'h01)));
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (done_evt)
            result_mem[HAS_DMA ? 4'h0 : buf_ptr] <= res.word;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= hit_ctrl1 ? {16'h0000, converter_control_one} :
                      hit_ctrl2 ? {16'h0000, ctrl2} :
                      hit_timing ? {16'h0000, timing} :
                      hit_status ? {26'h0, state, conv_cnt} :
                      hit_result ? {16'h0000, result_mem[HAS_DMA ? 4'h0 : buf_ptr]} :
                      hit_pin ? {16'h0000, pin_analog_config} :
                      (!HAS_DMA && rd_ok_buf) ? {16'h0000, result_mem[buf_sel]} :
                      32'h0000_0000;
    end

    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign pin_digital = pin_in & pin_analog_config & other_pin_config;
    assign sample_hold_track = state == SAC_SAMPLE;
    assign sample_enable = state != SAC_SAMPLE ? '0 : simultaneous_acquire ? '1 : NUM_SH'(1);
    assign conv_start = end_sample;
    assign conv_channel = ch_now;
    assign scan_restart = count_hit && scan_en;
endmodule // sac_ctrl
`default_nettype wire

// ==== src/sac_pkg.sv ====
// Purpose: shared constants for the converter sequencer control block
// Assumes: apb word registers, 200 MHz pclk
// Notes: offsets of all registers are local choices
package sac_pkg;
    localparam logic [11:0] ADDR_CTRL1 = 12'h000;
    localparam logic [11:0] ADDR_CTRL2 = 12'h004;
    localparam logic [11:0] ADDR_TIMING = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;
    localparam logic [11:0] ADDR_RESULT = 12'h010;
    localparam logic [11:0] ADDR_PINCFG = 12'h014;
    localparam logic [11:0] ADDR_BUFBASE = 12'h040;
    localparam int BIT_ON = 15;
    localparam int BIT_HALT_IDLE = 13;
    localparam int BIT_DMABM = 12;
    localparam int BIT_RES12 = 10;
    localparam int RESULT_LAYOUT_HI = 9;
    localparam int RESULT_LAYOUT_LO = 8;
    localparam int TRIG_HI = 7;
    localparam int TRIG_LO = 5;
    localparam int BIT_SIMULTANEOUS_ACQUIRE = 3;
    localparam int BIT_AUTO_ACQUIRE_START = 2;
    localparam int BIT_ACQUIRE_ACTIVE = 1;
    localparam int BIT_DONE = 0;
    localparam int BIT_SCAN = 10;
    localparam int CONVERSIONS_PER_INTERRUPT_HI = 5;
    localparam int CONVERSIONS_PER_INTERRUPT_LO = 2;
    localparam int SAMC_HI = 12;
    localparam int SAMC_LO = 8;
    localparam int DMABL_HI = 2;
    localparam int DMABL_LO = 0;
    localparam logic [15:0] CTRL1_WMASK = 16'hB7EE;
    localparam logic [15:0] CTRL2_WMASK = 16'h043C;
    localparam logic [15:0] TIMING_WMASK = 16'h1F07;
    localparam logic [15:0] RESET16 = 16'h0000;
    localparam logic [3:0] CH_LAST = 4'hC;
    localparam int NUM_SH = 4;
    typedef enum logic [2:0] {
        SAC_TRIG_MANUAL = 3'b000,
        SAC_TRIG_EXT = 3'b001,
        SAC_TRIG_TMR_B = 3'b010,
        SAC_TRIG_TMR_C = 3'b100,
        SAC_TRIG_AUTO = 3'b111
    } sac_trig_t;
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_SAMPLE = 2'b01,
        SAC_CONVERT = 2'b10
    } sac_state_t;
endpackage

// ==== src/sac_res_if.sv ====
// Purpose: result hand-off bundle between sequencer and formatter
// Assumes: single clock
// Notes: raw is right aligned
`timescale 1ns/1ps
`default_nettype none
interface sac_res_if;
    logic [11:0] raw;
    logic res12;
    logic [1:0] layout;
    logic [15:0] word;
    modport src (output raw, output res12, output layout, input word);
    modport fmt (input raw, input res12, input layout, output word);
endinterface
`default_nettype wire

// ==== src/sac_format.sv ====
// Purpose: result alignment and sign coding
// Assumes: raw data right aligned
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module sac_format (
    sac_res_if.fmt res
);
    import sac_pkg::*;
    wire logic [9:0] d10 = res.raw[9:0];
    wire logic [11:0] d12 = res.raw;
    wire logic [15:0] w10_int = {6'h00, d10};
    wire logic [15:0] w10_sint = {{7{~d10[9]}}, d10[8:0]};
    wire logic [15:0] w10_frac = {d10, 6'h00};
    wire logic [15:0] w10_sfrac = {~d10[9], d10[8:0], 6'h00};
    wire logic [15:0] w12_int = {4'h0, d12};
    wire logic [15:0] w12_sint = {{5{~d12[11]}}, d12[10:0]};
    wire logic [15:0] w12_frac = {d12, 4'h0};
    wire logic [15:0] w12_sfrac = {~d12[11], d12[10:0], 4'h0};
    wire logic [15:0] w10 = res.layout == 2'b00 ? w10_int :
                            res.layout == 2'b01 ? w10_sint :
                            res.layout == 2'b10 ? w10_frac : w10_sfrac;
    wire logic [15:0] w12 = res.layout == 2'b00 ? w12_int :
                            res.layout == 2'b01 ? w12_sint :
                            res.layout == 2'b10 ? w12_frac : w12_sfrac;
    assign res.word = res.res12 ? w12 : w10;
endmodule // sac_format
`default_nettype wire

// ==== sim/sac_core_model.sv ====
// Purpose: analog core stand-in that answers each conversion start
// Assumes: one result per conv_start, delay chosen by the bench
// Notes: data lines toggle outside the done pulse
`timescale 1ns/1ps
`default_nettype none
module sac_core_model (
    input wire logic pclk,
    input wire logic conv_start,
    input wire logic [11:0] value,
    input wire logic [3:0] delay,
    output logic conv_done,
    output logic [11:0] conv_data
);
    int cnt = -1;
    initial begin
        conv_done = 1'b0;
        conv_data = 12'h5A5;
    end
    always @(posedge pclk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (conv_start) cnt <= delay;
        else if (cnt > 0) cnt <= cnt - 1;
        else if (cnt == 0) begin
            conv_done <= 1'b1;
            conv_data <= value;
            cnt <= -1;
        end
    end
endmodule // sac_core_model
`default_nettype wire

// ==== sim/sac_ctrl_checker.sv ====
// Purpose: port-level checks of the sequencer control
// Assumes: control word tracked from apb writes
// Notes: attached by bind
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_checker
    import sac_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic cpu_idle,
    input wire logic general_timer_b,
    input wire logic [15:0] other_pin_config,
    input wire logic [15:0] pin_in,
    input wire logic [15:0] pin_digital,
    input wire logic sample_hold_track,
    input wire logic [NUM_SH-1:0] sample_enable,
    input wire logic conv_start,
    input wire logic [3:0] conv_channel,
    input wire logic converter_irq_flag,
    input wire logic dma_request
);
    logic [15:0] c1;
    wire wr1 = psel && penable && pwrite && paddr == ADDR_CTRL1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) c1 <= 16'h0000;
        else if (wr1) c1 <= pwdata[15:0];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_off_no_start: assert property (!c1[BIT_ON] |-> !conv_start)
        else $error("conversion start while off");
    a_one_sh: assert property (
        c1[BIT_RES12] && sample_hold_track |-> sample_enable == 4'h1)
        else $error("several holds in 12-bit mode");
    a_four_sh: assert property (
        !c1[BIT_RES12] && c1[BIT_SIMULTANEOUS_ACQUIRE] && sample_hold_track |-> sample_enable == 4'hF)
        else $error("simultaneous sampling missing");
    a_irq_dma: assert property (converter_irq_flag |-> dma_request)
        else $error("flag without dma request");
    a_irq_pulse: assert property (converter_irq_flag |=> !converter_irq_flag)
        else $error("flag longer than one cycle");
    a_chan_range: assert property (conv_channel <= CH_LAST)
        else $error("channel out of range");
    a_pin_both: assert property (
        (pin_digital & ~(pin_in & other_pin_config)) == 16'h0000)
        else $error("digital input without both configs");
    a_idle_halt: assert property (c1[BIT_HALT_IDLE] && cpu_idle |-> !conv_start)
        else $error("conversion while halted");
    a_timer_trig: assert property (
        c1[TRIG_HI:TRIG_LO] == SAC_TRIG_TMR_B && conv_start |-> general_timer_b)
        else $error("start without timer compare");
endmodule // sac_ctrl_checker
bind sac_ctrl sac_ctrl_checker chk (.*);
`default_nettype wire

// ==== sim/sar_adc_sequencer_control_test.sv ====
// Purpose: self-checking bench of the sequencer control
// Assumes: zero wait apb, core model answers starts
// Notes: seeded random data, channels and delays
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_control_test;
    import sac_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic cpu_idle, ext0, tmr_b, tmr_c, done, sht, cst, srs, irq, dreq;
    logic [11:0] paddr, cdata, value;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] scan_ch, man_ch, cch, dly;
    logic [NUM_SH-1:0] sh_en;
    logic [15:0] ocfg, pin_in, pin_dig, cfg;
    logic [10:0] dma_addr;
    logic [2:0] trg;
    int err_count = 0, compares = 0, seed = 2240, irq_n = 0, dreq_n = 0, scan_n = 0;
    sac_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cpu_idle(cpu_idle), .external_interrupt_zero(ext0),
        .general_timer_b(tmr_b), .general_timer_c(tmr_c), .scan_channel(scan_ch),
        .manual_channel(man_ch), .conv_done(done), .conv_data(cdata),
        .other_pin_config(ocfg), .pin_in(pin_in), .pin_digital(pin_dig),
        .sample_hold_track(sht), .sample_enable(sh_en), .conv_start(cst),
        .conv_channel(cch), .scan_restart(srs), .converter_irq_flag(irq),
        .dma_request(dreq), .dma_address(dma_addr));
    sac_core_model core (.pclk(pclk), .conv_start(cst), .value(value), .delay(dly),
        .conv_done(done), .conv_data(cdata));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (irq === 1'b1) irq_n++;
        if (dreq === 1'b1) dreq_n++;
        if (srs === 1'b1) scan_n++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [15:0] fmt(input logic [11:0] r, input logic res,
        input logic [1:0] f);
        logic [15:0] l;
        l = res ? {r, 4'h0} : {r[9:0], 6'h00};
        case (f)
            2'b00: return res ? {4'h0, r} : {6'h00, r[9:0]};
            2'b01: return res ? {{5{~r[11]}}, r[10:0]} : {{7{~r[9]}}, r[8:0]};
            2'b10: return l;
            default: return {~l[15], l[14:0]};
        endcase
    endfunction
    task automatic conv(input logic [15:0] c, input logic by_trig);
        int n;
        n = 0;
        dly <= 4'($random(seed));
        man_ch <= 4'({$random(seed)} % 13);
        scan_ch <= 4'({$random(seed)} % 13);
        apb(1'b1, ADDR_CTRL1, {16'h0, c});
        apb(1'b1, ADDR_CTRL1, {16'h0, c | 16'h0002});
        if (by_trig) begin
            @(posedge pclk);
            tmr_b <= c[TRIG_HI:TRIG_LO] == SAC_TRIG_TMR_B;
            tmr_c <= c[TRIG_HI:TRIG_LO] == SAC_TRIG_TMR_C;
            ext0 <= c[TRIG_HI:TRIG_LO] == SAC_TRIG_EXT;
            @(posedge pclk);
            {tmr_b, tmr_c, ext0} <= 3'h0;
        end else apb(1'b1, ADDR_CTRL1, {16'h0, c});
        do begin
            apb(1'b0, ADDR_CTRL1, 32'h0);
            n++;
        end while (rd[BIT_DONE] !== 1'b1 && n < 40);
        chk({31'h0, rd[BIT_DONE]}, 32'h1);
    endtask
    initial begin
        {psel, penable, pwrite, cpu_idle, ext0, tmr_b, tmr_c} = 7'h00;
        {paddr, pwdata, scan_ch, man_ch, dly, value, ocfg, pin_in} = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 12'h100, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, ADDR_CTRL1, 32'h7FFD);
        apb(1'b0, ADDR_CTRL1, 32'h0);
        chk(rd, {16'h0, 16'h7FFD & CTRL1_WMASK});
        apb(1'b1, ADDR_CTRL1, 32'h8008);
        apb(1'b1, ADDR_CTRL1, 32'h800A);
        @(posedge pclk);
        chk({28'h0, sh_en}, 32'hF);
        apb(1'b1, ADDR_CTRL1, 32'h0400);
        apb(1'b1, ADDR_CTRL1, 32'h8408);
        apb(1'b1, ADDR_CTRL1, 32'h840A);
        @(posedge pclk);
        chk({28'h0, sh_en}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            trg = i[0] ? (i[1] ? (i[2] ? 3'h7 : 3'h4) : (i[2] ? 3'h1 : 3'h2)) : 3'h0;
            cfg = {3'h4, i[1], 1'b0, i[2], i[1:0], trg, 5'h00};
            apb(1'b1, ADDR_CTRL1, {17'h0, cfg[14:0]});
            value = 12'($random(seed)) & (i[2] ? 12'hFFF : 12'h3FF);
            conv(cfg, i[0]);
            chk({21'h0, dma_addr}, i[1] ? 32'h0 : {28'h0, man_ch});
            apb(1'b0, ADDR_RESULT, 32'h0);
            chk(rd, {16'h0, fmt(value, i[2], i[1:0])});
            apb(1'b1, ADDR_CTRL1, {16'h0, cfg});
            apb(1'b0, ADDR_CTRL1, 32'h0);
            chk({31'h0, rd[BIT_DONE]}, 32'h0);
        end
        chk(irq_n, 8);
        chk(dreq_n, 8);
        apb(1'b1, ADDR_CTRL1, 32'h0);
        for (int c = 2; c < 16; c += 13) begin
            apb(1'b1, ADDR_CTRL2, 32'(16'h0400 | 16'(c << 2)));
            irq_n = 0;
            scan_n = 0;
            for (int j = 0; j <= c; j++) begin
                conv(16'h8000, 1'b0);
                chk(irq_n, (j == c) ? 1 : 0);
            end
            chk(scan_n, 1);
        end
        cpu_idle <= 1'b1;
        apb(1'b1, ADDR_CTRL1, 32'hA000);
        apb(1'b1, ADDR_CTRL1, 32'hA002);
        apb(1'b1, ADDR_CTRL1, 32'hA000);
        repeat (20) @(posedge pclk);
        apb(1'b0, ADDR_CTRL1, 32'h0);
        chk({31'h0, rd[BIT_DONE]}, 32'h0);
        apb(1'b1, ADDR_PINCFG, 32'hFFFF);
        pin_in <= 16'($random(seed));
        ocfg <= 16'($random(seed));
        repeat (2) @(posedge pclk);
        chk({16'h0, pin_dig}, {16'h0, pin_in & ocfg});
        end_of_test;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        end_of_test;
    end
endmodule // sar_adc_sequencer_control_test
`default_nettype wire
